/* sspsq_asserts.sv */
// Concurrent checks on the supply sequencer top-level ports
`timescale 1ns/10ps
`default_nettype none
module sspsq_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Comparator inputs
  input wire logic hv_input_below_rst,
  input wire logic ic_supply_below_rst,
  input wire logic en_above_boost_threshold,
  input wire logic en_above_full_threshold,
  input wire logic overtemp_active,
  input wire logic hb_low_side_active,
  // Enables and timing pin drive
  input wire logic boost_controller_en,
  input wire logic half_bridge_controller_en,
  input wire logic hb_low_side_force,
  input wire logic hv_source_en,
  input wire logic regulator_en,
  input wire logic timing_pin_charge_slow,
  input wire logic timing_pin_charge_fast,
  input wire logic timing_pin_discharge
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Six cycles cover the three-flop sync, the agreement flop and the state edge
  chk_nosup_off: assert property (
    (hv_input_below_rst && ic_supply_below_rst)[*6]
    |-> !boost_controller_en && !half_bridge_controller_en
    && !hv_source_en && !regulator_en)
    else $error("outputs on without supply");
  chk_dis_off: assert property (
    (!en_above_boost_threshold)[*6]
    |-> !boost_controller_en && !hv_source_en && !regulator_en)
    else $error("outputs on while disabled");
  chk_hold_off: assert property (
    overtemp_active[*6]
    |-> !boost_controller_en && !hv_source_en && !regulator_en)
    else $error("outputs on in thermal hold");
  chk_mid_en: assert property (
    (en_above_boost_threshold && hb_low_side_active
    && !en_above_full_threshold)[*6] |-> !half_bridge_controller_en)
    else $error("half bridge on below full enable");
  chk_force_ls: assert property (
    hb_low_side_force |-> !half_bridge_controller_en && !hv_source_en)
    else $error("low side forced with bridge on");
  chk_boost_reg: assert property (
    boost_controller_en |-> regulator_en)
    else $error("boost without regulator");
  chk_restart_drv: assert property (
    timing_pin_charge_fast |-> !boost_controller_en
    && !timing_pin_discharge && !timing_pin_charge_slow)
    else $error("fast charge outside restart");
  chk_slow_dis: assert property (
    timing_pin_charge_slow |-> !timing_pin_discharge
    && !timing_pin_charge_fast)
    else $error("slow charge fights discharge");
  chk_hb_start: assert property (
    $rose(half_bridge_controller_en)
    |-> regulator_en && boost_controller_en && !hv_source_en)
    else $error("half bridge started early");
  chk_reg_seq: assert property (
    $rose(regulator_en) |-> hv_source_en)
    else $error("regulator before supply charge");
endmodule // sspsq_asserts
bind sspsq_top sspsq_asserts chk_u (.pclk, .presetn, .hv_input_below_rst,
  .ic_supply_below_rst, .en_above_boost_threshold, .en_above_full_threshold,
  .overtemp_active, .hb_low_side_active, .boost_controller_en,
  .half_bridge_controller_en, .hb_low_side_force, .hv_source_en,
  .regulator_en, .timing_pin_charge_slow, .timing_pin_charge_fast,
  .timing_pin_discharge);
`default_nettype wire

/* sspsq_params.svh */
// Offsets, field positions and reset values of the supply sequencer
`ifndef SSPSQ_PARAMS_SVH
`define SSPSQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SSPSQ_CTRL_OFFSET 8'h00
`define SSPSQ_STATUS_OFFSET 8'h04

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define SSPSQ_CTRL_TIMED_SHDN_BIT 0
`define SSPSQ_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SSPSQ_STAT_STATE_LSB 0
`define SSPSQ_STAT_HB_RUN_BIT 9
`define SSPSQ_STAT_BOOST_BIT 10
`define SSPSQ_STAT_MAINS_SEEN_BIT 11
`define SSPSQ_STAT_FLAGS_LSB 16

// ----------------------------------------------------------------
// Positions of the comparator flags in the synchronised vector
// ----------------------------------------------------------------
`define SSPSQ_F_HV_LOW 0
`define SSPSQ_F_IC_LOW 1
`define SSPSQ_F_IC_START 2
`define SSPSQ_F_REG_START 3
`define SSPSQ_F_BOOST_OK 4
`define SSPSQ_F_EN_BOOST 5
`define SSPSQ_F_EN_FULL 6
`define SSPSQ_F_OTP 7
`define SSPSQ_F_MAINS_LOW 8
`define SSPSQ_F_RESTART_PROT 9
`define SSPSQ_F_SHDN_PROT 10
`define SSPSQ_F_TIMED_ERR 11
`define SSPSQ_F_TMR_UPPER 12
`define SSPSQ_F_TMR_LOWER 13
`define SSPSQ_F_LS_ACTIVE 14
`define SSPSQ_NUM_FLAGS 15

`endif

/* sspsq_pkg.sv */
// Types shared by the supply sequencer modules
package sspsq_pkg;

  // Operating states, one-hot
  typedef enum logic [8:0] {
    SSPSQ_NO_SUPPLY = 9'h001,
    SSPSQ_DISABLED = 9'h002,
    SSPSQ_THERMAL = 9'h004,
    SSPSQ_IC_CHARGE = 9'h008,
    SSPSQ_REG_CHARGE = 9'h010,
    SSPSQ_BOOST_CHARGE = 9'h020,
    SSPSQ_OPERATIONAL = 9'h040,
    SSPSQ_RESTART = 9'h080,
    SSPSQ_SHUTDOWN = 9'h100
  } sspsq_state_t;

  // Timing pin states, one-hot
  typedef enum logic [5:0] {
    SSPSQ_TMR_IDLE = 6'h01,
    SSPSQ_TMR_PROT_CHARGE = 6'h02,
    SSPSQ_TMR_PROT_RELEASE = 6'h04,
    SSPSQ_TMR_RST_CHARGE = 6'h08,
    SSPSQ_TMR_RST_RELEASE = 6'h10,
    SSPSQ_TMR_DUMP = 6'h20
  } sspsq_tmr_state_t;

endpackage

/* sspsq_rc_model.sv */
// Behavioural RC network on the timing pin with its two comparators
`timescale 1ns/10ps
`default_nettype none
module sspsq_rc_model (
  // Clock
  input wire logic pclk,
  // Pin drive and external pull-up
  input wire logic timing_pin_charge_slow,
  input wire logic timing_pin_charge_fast,
  input wire logic timing_pin_discharge,
  input wire logic force_high,
  // Comparators
  output logic timer_above_upper_level,
  output logic timer_above_lower_level
);
  int v = 0;
  // Pin voltage in steps; release decays slowly through the resistor
  always @(posedge pclk) begin
    if (timing_pin_discharge) v <= (v > 4) ? v - 4 : 0;
    else if (timing_pin_charge_fast) v <= v + 8;
    else if (timing_pin_charge_slow) v <= v + 1;
    else if (v > 0) v <= v - 1;
  end
  // External circuit may lift the pin above both levels
  assign timer_above_upper_level = force_high || v >= 40;
  assign timer_above_lower_level = force_high || v >= 5;
endmodule // sspsq_rc_model
`default_nettype wire

/* sspsq_sync.sv */
// Three-stage synchroniser with agreement filter for comparator flags
`timescale 1ns/10ps
`default_nettype none
module sspsq_sync #(
  parameter int W = 15
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Flags
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sspsq_sync_st_t;

  sspsq_sync_st_t r;
  sspsq_sync_st_t n;

  // Stage one feeds only stage two; a bit counts once stages two and
  // three agree, so a single sample caught mid-change is never used
  always_comb begin
    n = r;
    n.s1 = async_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.q[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.q;
endmodule // sspsq_sync
`default_nettype wire

/* sspsq_timer.sv */
// Protection and restart timer driving the external RC timing pin
`timescale 1ns/10ps
`default_nettype none
module sspsq_timer
  import sspsq_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to the core
  sspsq_timer_if.timer tif
);
  typedef struct packed {
    sspsq_tmr_state_t st;
    logic charge_slow;
    logic charge_fast;
    logic discharge;
    logic prot_expired;
    logic force_restart;
    logic restart_due;
  } sspsq_tmr_st_t;

  sspsq_tmr_st_t r;
  sspsq_tmr_st_t n;

  // Timer sequencing; a restart request overrides protection timing
  always_comb begin
    n = r;
    n.prot_expired = 1'b0;
    n.force_restart = 1'b0;
    n.restart_due = 1'b0;
    if (tif.restart_start) begin
      n.st = SSPSQ_TMR_RST_CHARGE;
    end else begin
      case (r.st)
        SSPSQ_TMR_IDLE: begin
          if (tif.above_upper) begin
            n.force_restart = 1'b1;
            n.st = SSPSQ_TMR_DUMP;
          end else if (tif.prot_arm) begin
            n.st = SSPSQ_TMR_PROT_CHARGE;
          end
        end
        SSPSQ_TMR_PROT_CHARGE: begin
          if (tif.above_upper) begin
            n.prot_expired = 1'b1;
            n.st = SSPSQ_TMR_DUMP;
          end else if (!tif.prot_arm) begin
            n.st = SSPSQ_TMR_PROT_RELEASE;
          end
        end
        SSPSQ_TMR_PROT_RELEASE: begin
          // Let the resistor bleed the cap; no action is taken
          if (tif.prot_arm) begin
            n.st = SSPSQ_TMR_PROT_CHARGE;
          end else if (!tif.above_lower) begin
            n.st = SSPSQ_TMR_IDLE;
          end
        end
        SSPSQ_TMR_RST_CHARGE: begin
          if (tif.above_upper) begin
            n.st = SSPSQ_TMR_RST_RELEASE;
          end
        end
        SSPSQ_TMR_RST_RELEASE: begin
          if (!tif.above_lower) begin
            n.restart_due = 1'b1;
            n.st = SSPSQ_TMR_DUMP;
          end
        end
        SSPSQ_TMR_DUMP: begin
          // Hold the switch until the pin falls below the lower level, so the stale charge
          // is not mistaken for an external force
          if (!tif.above_lower) begin
            n.st = SSPSQ_TMR_IDLE;
          end
        end
        default: begin
          n.st = SSPSQ_TMR_IDLE;
        end
      endcase
    end
    // Pin drive follows the coming state
    n.charge_slow = (n.st == SSPSQ_TMR_PROT_CHARGE);
    n.charge_fast = (n.st == SSPSQ_TMR_RST_CHARGE);
    n.discharge = (n.st == SSPSQ_TMR_IDLE) || (n.st == SSPSQ_TMR_DUMP);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: SSPSQ_TMR_IDLE, discharge: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign tif.charge_slow = r.charge_slow;
  assign tif.charge_fast = r.charge_fast;
  assign tif.discharge = r.discharge;
  assign tif.prot_expired = r.prot_expired;
  assign tif.force_restart = r.force_restart;
  assign tif.restart_due = r.restart_due;
endmodule // sspsq_timer
`default_nettype wire

/* sspsq_timer_if.sv */
// Link between the sequencer core and the timing pin controller
`timescale 1ns/10ps
`default_nettype none
interface sspsq_timer_if;
  logic prot_arm;
  logic restart_start;
  logic above_upper;
  logic above_lower;
  logic prot_expired;
  logic force_restart;
  logic restart_due;
  logic charge_slow;
  logic charge_fast;
  logic discharge;

  // Core side
  modport core (
    output prot_arm, restart_start, above_upper, above_lower,
    input prot_expired, force_restart, restart_due,
    input charge_slow, charge_fast, discharge
  );

  // Timer side
  modport timer (
    input prot_arm, restart_start, above_upper, above_lower,
    output prot_expired, force_restart, restart_due,
    output charge_slow, charge_fast, discharge
  );
endinterface
`default_nettype wire

/* sspsq_top.sv */
// Supply state and protection sequencer with APB register access
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
`include "sspsq_params.svh"
`default_nettype none

module sspsq_top
  import sspsq_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply comparators
  input wire logic hv_input_below_rst,
  input wire logic ic_supply_below_rst,
  input wire logic ic_supply_start_ok,
  input wire logic regulated_supply_start_ok,
  input wire logic boost_voltage_ok,
  // Enable pin comparators
  input wire logic en_above_boost_threshold,
  input wire logic en_above_full_threshold,
  // Protection flags
  input wire logic overtemp_active,
  input wire logic mains_sense_below_rst,
  input wire logic restart_protection,
  input wire logic shutdown_protection,
  input wire logic timed_error,
  // Timing pin comparators
  input wire logic timer_above_upper_level,
  input wire logic timer_above_lower_level,
  // Half-bridge feedback
  input wire logic hb_low_side_active,
  // Controller and source enables
  output logic boost_controller_en,
  output logic half_bridge_controller_en,
  output logic hb_low_side_force,
  output logic hv_source_en,
  output logic regulator_en,
  // Timing pin drive
  output logic timing_pin_charge_slow,
  output logic timing_pin_charge_fast,
  output logic timing_pin_discharge
);
  import sspsq_pkg::*;

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    sspsq_state_t state;
    logic hb_run;
    logic boost_run;
    logic ls_force;
    logic hv_src;
    logic reg_on;
    logic mains_seen_low;
    logic prot_arm;
    logic restart_start;
    logic timed_shdn;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sspsq_top_st_t;

  sspsq_top_st_t r;
  sspsq_top_st_t n;

  logic [`SSPSQ_NUM_FLAGS-1:0] flags_async;
  logic [`SSPSQ_NUM_FLAGS-1:0] f;

  sspsq_timer_if tif ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // States in which the start-up sequence or normal running is active
  function automatic logic is_active(input sspsq_state_t s);
    return (s == SSPSQ_IC_CHARGE) || (s == SSPSQ_REG_CHARGE) ||
           (s == SSPSQ_BOOST_CHARGE) || (s == SSPSQ_OPERATIONAL);
  endfunction

  // Exact match on all eight address bits
  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // Flag synchronisation
  // ----------------------------------------------------------------

  // Comparator outputs are analog-domain levels
  assign flags_async = {
    hb_low_side_active,
    timer_above_lower_level,
    timer_above_upper_level,
    timed_error,
    shutdown_protection,
    restart_protection,
    mains_sense_below_rst,
    overtemp_active,
    en_above_full_threshold,
    en_above_boost_threshold,
    boost_voltage_ok,
    regulated_supply_start_ok,
    ic_supply_start_ok,
    ic_supply_below_rst,
    hv_input_below_rst
  };

  sspsq_sync #(
    .W(`SSPSQ_NUM_FLAGS)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(flags_async),
    .sync_out(f)
  );

  sspsq_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif.timer)
  );

  // Timer link fed from registers and synchronised comparators
  assign tif.prot_arm = r.prot_arm;
  assign tif.restart_start = r.restart_start;
  assign tif.above_upper = f[`SSPSQ_F_TMR_UPPER];
  assign tif.above_lower = f[`SSPSQ_F_TMR_LOWER];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.restart_start = 1'b0;

    // Operating state, highest priority first
    if (f[`SSPSQ_F_HV_LOW] && f[`SSPSQ_F_IC_LOW]) begin
      n.state = SSPSQ_NO_SUPPLY;
    end else if (!f[`SSPSQ_F_EN_BOOST]) begin
      n.state = SSPSQ_DISABLED;
    end else if (f[`SSPSQ_F_OTP]) begin
      n.state = SSPSQ_THERMAL;
    end else begin
      case (r.state)
        SSPSQ_NO_SUPPLY, SSPSQ_DISABLED, SSPSQ_THERMAL: begin
          n.state = SSPSQ_IC_CHARGE;
        end
        SSPSQ_SHUTDOWN: begin
          // Latched; only a mains dip and recovery opens it here
          if (f[`SSPSQ_F_MAINS_LOW]) begin
            n.mains_seen_low = 1'b1;
          end else if (r.mains_seen_low) begin
            n.state = SSPSQ_IC_CHARGE;
          end
        end
        SSPSQ_RESTART: begin
          if (tif.restart_due) begin
            n.state = SSPSQ_IC_CHARGE;
          end
        end
        SSPSQ_IC_CHARGE, SSPSQ_REG_CHARGE,
        SSPSQ_BOOST_CHARGE, SSPSQ_OPERATIONAL: begin
          if (f[`SSPSQ_F_SHDN_PROT] ||
              (tif.prot_expired && r.timed_shdn)) begin
            n.state = SSPSQ_SHUTDOWN;
          end else if (f[`SSPSQ_F_RESTART_PROT] || tif.force_restart ||
                       (tif.prot_expired && !r.timed_shdn)) begin
            n.state = SSPSQ_RESTART;
          end else begin
            case (r.state)
              SSPSQ_IC_CHARGE: begin
                if (f[`SSPSQ_F_IC_START]) begin
                  n.state = SSPSQ_REG_CHARGE;
                end
              end
              SSPSQ_REG_CHARGE: begin
                if (f[`SSPSQ_F_REG_START] && f[`SSPSQ_F_IC_START]) begin
                  n.state = SSPSQ_BOOST_CHARGE;
                end
              end
              SSPSQ_BOOST_CHARGE: begin
                if (f[`SSPSQ_F_BOOST_OK]) begin
                  n.state = SSPSQ_OPERATIONAL;
                end
              end
              default: begin
                n.state = r.state;
              end
            endcase
          end
        end
        default: begin
          n.state = SSPSQ_NO_SUPPLY;
        end
      endcase
    end

    // Mains dip memory only lives inside the latched state
    if (n.state != SSPSQ_SHUTDOWN) begin
      n.mains_seen_low = 1'b0;
    end

    // One-cycle timer kick on entry to restart
    n.restart_start = (n.state == SSPSQ_RESTART) &&
                      (r.state != SSPSQ_RESTART);

    // Timed errors only count while the controllers are starting or on
    n.prot_arm = f[`SSPSQ_F_TIMED_ERR] && is_active(n.state);

    // Boost stops at once when its state or enable goes away
    n.boost_run = ((n.state == SSPSQ_BOOST_CHARGE) ||
                   (n.state == SSPSQ_OPERATIONAL)) &&
                  f[`SSPSQ_F_EN_BOOST];

    // Half-bridge finishes to a low-side stroke before stopping, so
    // the bootstrap cap is left charged; a supply reset cuts it hard
    if ((n.state == SSPSQ_OPERATIONAL) && f[`SSPSQ_F_EN_FULL]) begin
      n.hb_run = 1'b1;
    end else if (n.state == SSPSQ_NO_SUPPLY) begin
      n.hb_run = 1'b0;
    end else if (f[`SSPSQ_F_LS_ACTIVE]) begin
      n.hb_run = 1'b0;
    end

    // Low side held on while the enable pin keeps the bridge idle
    n.ls_force = !n.hb_run && !f[`SSPSQ_F_EN_FULL] &&
                 ((n.state == SSPSQ_OPERATIONAL) ||
                  (n.state == SSPSQ_DISABLED));

    // High-voltage source charges the IC supply during start-up
    n.hv_src = (n.state == SSPSQ_IC_CHARGE) ||
               (n.state == SSPSQ_REG_CHARGE) ||
               (n.state == SSPSQ_BOOST_CHARGE) ||
               (n.state == SSPSQ_RESTART);

    // Regulator only after the IC supply cap is full
    n.reg_on = (n.state == SSPSQ_REG_CHARGE) ||
               (n.state == SSPSQ_BOOST_CHARGE) ||
               (n.state == SSPSQ_OPERATIONAL);

    // APB: answer one cycle into the access phase
    n.pready = psel && penable && !r.pready;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (n.pready) begin
      if (addr_is(paddr, `SSPSQ_CTRL_OFFSET)) begin
        n.prdata[`SSPSQ_CTRL_TIMED_SHDN_BIT] = r.timed_shdn;
      end else if (addr_is(paddr, `SSPSQ_STATUS_OFFSET)) begin
        n.prdata[`SSPSQ_STAT_STATE_LSB +: 9] = r.state;
        n.prdata[`SSPSQ_STAT_HB_RUN_BIT] = r.hb_run;
        n.prdata[`SSPSQ_STAT_BOOST_BIT] = r.boost_run;
        n.prdata[`SSPSQ_STAT_MAINS_SEEN_BIT] = r.mains_seen_low;
        n.prdata[`SSPSQ_STAT_FLAGS_LSB +: `SSPSQ_NUM_FLAGS] = f;
      end else begin
        n.pslverr = 1'b1;
      end
    end

    // Writes land at the edge where the master sees pready
    if (psel && penable && r.pready && pwrite &&
        addr_is(paddr, `SSPSQ_CTRL_OFFSET)) begin
      n.timed_shdn = pwdata[`SSPSQ_CTRL_TIMED_SHDN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{
        state: SSPSQ_NO_SUPPLY,
        timed_shdn: 1'(`SSPSQ_CTRL_RESET >> `SSPSQ_CTRL_TIMED_SHDN_BIT),
        prdata: 32'h0000_0000,
        default: '0
      };
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // All straight from flip-flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign boost_controller_en = r.boost_run;
  assign half_bridge_controller_en = r.hb_run;
  assign hb_low_side_force = r.ls_force;
  assign hv_source_en = r.hv_src;
  assign regulator_en = r.reg_on;
  assign timing_pin_charge_slow = tif.charge_slow;
  assign timing_pin_charge_fast = tif.charge_fast;
  assign timing_pin_discharge = tif.discharge;
endmodule // sspsq_top
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the supply state and protection sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic mains, rp, sp, te, frc;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [8:0] fl;
  logic [4:0] outs;
  logic boost_controller_en, half_bridge_controller_en, hb_low_side_force;
  logic hv_source_en, regulator_en, timer_above_upper_level;
  logic timing_pin_charge_slow, timing_pin_charge_fast, timing_pin_discharge;
  logic timer_above_lower_level;
  int n_fail, samples_checked;
  localparam logic [8:0] OPER = 9'b001111101;
  // Flags {hv,ic,ic_st,reg_st,bst_ok,en_b,en_f,otp,ls}, then expected outs
  logic [13:0] rows [11] = '{14'b110001100_00000, 14'b000000000_00100,
    14'b000001100_00010, 14'b001001100_00011, 14'b001101100_10011,
    14'b001111100_11001, 14'b001111001_10101, 14'b001111011_00000,
    14'b001111001_10101, 14'b001111100_11001, 14'b110001100_00000};
  assign outs = {boost_controller_en, half_bridge_controller_en,
    hb_low_side_force, hv_source_en, regulator_en};
  sspsq_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hv_input_below_rst(fl[8]),
    .ic_supply_below_rst(fl[7]), .ic_supply_start_ok(fl[6]),
    .regulated_supply_start_ok(fl[5]), .boost_voltage_ok(fl[4]),
    .en_above_boost_threshold(fl[3]), .en_above_full_threshold(fl[2]),
    .overtemp_active(fl[1]), .mains_sense_below_rst(mains),
    .restart_protection(rp), .shutdown_protection(sp), .timed_error(te),
    .timer_above_upper_level, .timer_above_lower_level,
    .hb_low_side_active(fl[0]), .boost_controller_en,
    .half_bridge_controller_en, .hb_low_side_force, .hv_source_en,
    .regulator_en, .timing_pin_charge_slow, .timing_pin_charge_fast,
    .timing_pin_discharge);
  sspsq_rc_model rc_u (.pclk, .timing_pin_charge_slow, .timing_pin_charge_fast,
    .timing_pin_discharge, .force_high(frc), .timer_above_upper_level,
    .timer_above_lower_level);
  // Clock and watchdog; the bench needs well under 1000 cycles
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    report_and_stop;
  end
  task go(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wait_hb;
    int n;
    n = 0;
    while (half_bridge_controller_en !== 1'b1 && n < 600) begin
      @(posedge pclk);
      n++;
    end
    chk("hb back", 1, half_bridge_controller_en);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Table walk, then restart, timer, shutdown and reset cases
  initial begin
    {presetn, psel, penable, pwrite, mains, rp, sp, te, frc} = 0;
    {paddr, pwdata, fl, n_fail, samples_checked} = 0;
    go(2);
    chk("idle drain", 1, timing_pin_discharge);
    presetn <= 1;
    foreach (rows[i]) begin
      fl <= rows[i][13:5];
      go(10);
      chk("outs", rows[i][4:0], outs);
    end
    fl <= OPER;
    go(30);
    rp <= 1;
    go(6);
    chk("restart", 2'b10, {hv_source_en, regulator_en});
    go(1);
    chk("fast", 1, timing_pin_charge_fast);
    rp <= 0;
    wait_hb;
    te <= 1;
    go(8);
    chk("slow", 1, timing_pin_charge_slow);
    te <= 0;
    go(60);
    chk("no action", 1, half_bridge_controller_en);
    apb(1, 8'h00, 32'h0000_0001);
    te <= 1;
    go(80);
    te <= 0;
    go(40);
    chk("shut outs", 0, outs);
    apb(0, 8'h04, 32'h0);
    chk("state", 9'h100, q[8:0]);
    apb(0, 8'h08, 32'h0);
    chk("unmapped", 1, e);
    mains <= 1;
    go(6);
    mains <= 0;
    wait_hb;
    sp <= 1;
    go(6);
    sp <= 0;
    go(40);
    chk("latched", 0, outs);
    fl <= 9'b001110001;
    go(10);
    fl <= OPER;
    wait_hb;
    apb(1, 8'h00, 32'h0);
    frc <= 1;
    go(7);
    chk("forced", 1, hv_source_en);
    frc <= 0;
    wait_hb;
    presetn <= 0;
    go(2);
    chk("reset outs", 0, outs);
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
